// ==== verilog/scgs_pkg.sv ====
// constants and carrier types for the serial receive front end
// assumes one 10 MHz clock and quad-octet words from each deserializer lane
package scgs_pkg;

  // ----------------------------------------------------------------------
  // register offsets
  // ----------------------------------------------------------------------
  localparam logic [11:0] ADDR_REF_RATE  = 12'h084;
  localparam logic [11:0] ADDR_IF_POWER  = 12'h200;
  localparam logic [11:0] ADDR_LANE_PD   = 12'h201;
  localparam logic [11:0] ADDR_CDR_RST   = 12'h206;
  localparam logic [11:0] ADDR_CDR_MODE  = 12'h230;
  localparam logic [11:0] ADDR_EQ_MODE   = 12'h268;
  localparam logic [11:0] ADDR_PLL_CTRL  = 12'h280;
  localparam logic [11:0] ADDR_PLL_STAT  = 12'h281;
  localparam logic [11:0] ADDR_PLL_DIV   = 12'h289;

  // ----------------------------------------------------------------------
  // field positions and reset values
  // ----------------------------------------------------------------------
  localparam int IF_PD_BIT        = 0;
  localparam int REF_RATE_LSB     = 4;
  localparam int CDR_RST_BIT      = 0;
  localparam int HALF_RATE_BIT    = 5;
  localparam int CDR_DIV_LSB      = 1;
  localparam int EQ_MODE_LSB      = 6;
  localparam int PLL_EN_BIT       = 0;
  localparam int PLL_RECAL_BIT    = 2;
  localparam int STAT_LOCK_BIT    = 0;
  localparam int STAT_CAL_BIT     = 3;
  localparam int STAT_BAND_LO_BIT = 4;
  localparam int STAT_BAND_HI_BIT = 5;
  localparam logic [7:0] RST_IF_POWER = 8'h01;
  localparam logic [7:0] RST_DEFAULT  = 8'h00;

  // divider field codes and equalizer modes
  localparam logic [1:0] DIV_BY4   = 2'h0;
  localparam logic [1:0] DIV_BY2   = 2'h1;
  localparam logic [1:0] DIV_BY1   = 2'h2;
  localparam logic [1:0] EQ_NORMAL = 2'h0;
  localparam logic [1:0] EQ_LOWPWR = 2'h1;

  // ----------------------------------------------------------------------
  // link characters and timing
  // ----------------------------------------------------------------------
  localparam logic [7:0] K_SYNC   = 8'hBC;
  localparam logic [7:0] K_ALIGN  = 8'h7C;
  localparam logic [7:0] K_LSTART = 8'h1C;
  localparam logic [2:0] CGS_RUN  = 3'h4;
  localparam int CLK_PERIOD_NS = 100;
  localparam int CAL_TIME_NS   = 5000;
  localparam int CAL_CYCLES    = (CAL_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;
  localparam int LOCK_TIME_NS  = 2000;
  localparam int LOCK_CYCLES   = (LOCK_TIME_NS + CLK_PERIOD_NS - 1)
                                 / CLK_PERIOD_NS;

  // ----------------------------------------------------------------------
  // carriers
  // ----------------------------------------------------------------------
  typedef struct packed {
    logic [31:0] data;   // octet 0 in [7:0] arrives first
    logic [3:0]  is_k;
  } scgs_lane_word_t;

  typedef struct packed {
    logic       if_pd;
    logic       pll_en;
    logic       ref_2x;
    logic [1:0] pfd_div;
    logic       cdr_half;
    logic [1:0] cdr_div;
    logic       cdr_rst;
    logic       eq_low_power;
    logic [7:0] lane_pd;
  } scgs_phy_ctrl_t;

endpackage

// ==== verilog/scgs_rx_front.sv ====
// serial receive front end: pll control, cdr/eq/lane setup, code group
// sync and lane alignment through per-lane elastic buffers
// assumes register strobes from the serial control port, decoded quad
// octets per lane per clock, and an lmfc tick pulse from a divider
`timescale 1ns/1ps

// Operation
// - reference is lane rate/40; phase detector tick is reference divided by field
// - rising edge of control bit 2 starts a pll recalibration
// - status bit 0 shows lock, bit 3 shows calibration success
// - status bits 4 and 5 flag lower and upper calibration band end
// - a lane is powered off while its power-down bit is one
// - equalizer field 01 selects low power, 00 selects normal mode
// - receiver requests synchronization by driving its request output low
// - after four K28.5 on all lanes, release request at next lmfc edge
// - lanes align on the /A/ to /R/ character transition
// - elastic buffers hold early lanes, release all lanes together
// - all lanes not powered down do code group and frame sync as one link
// - four octets per lane handled in each processing cycle
module scgs_rx_front #(
  parameter int LANES = 8,
  parameter int DEPTH = 8
) (
  input  wire logic                   clk,
  input  wire logic                   srst,
  input  wire logic [11:0]            reg_addr,
  input  wire logic                   reg_wr,
  input  wire logic                   reg_rd,
  input  wire logic [7:0]             reg_wdata,
  output logic [7:0]                  reg_rdata,
  input  wire logic                   ref_tick,
  output logic                        pfd_tick,
  input  wire logic                   vco_band_lo,
  input  wire logic                   vco_band_hi,
  output scgs_pkg::scgs_phy_ctrl_t    phy_ctrl,
  input  wire logic                   lmfc_tick,
  input  wire scgs_pkg::scgs_lane_word_t [LANES-1:0] lane_in,
  input  wire logic [LANES-1:0]       lane_valid,
  input  wire logic [LANES-1:0]       lane_code_err,
  output logic                        link_sync_request_out,
  output logic                        aligned_valid,
  output logic [LANES-1:0][31:0]      aligned_data,
  output logic                        align_overflow
);

  localparam int AW = $clog2(DEPTH);

  // ----------------------------------------------------------------------
  // register file
  // ----------------------------------------------------------------------
  logic [7:0] ref_rate_r, if_power_r, lane_pd_r, cdr_rst_r;
  logic [7:0] cdr_mode_r, eq_mode_r, pll_ctrl_r, pll_div_r;
  logic [7:0] pll_stat;

  // writable registers, status is read only
  always_ff @(posedge clk) begin
    if (srst) begin
      ref_rate_r <= scgs_pkg::RST_DEFAULT;
      if_power_r <= scgs_pkg::RST_IF_POWER;
      lane_pd_r  <= scgs_pkg::RST_DEFAULT;
      cdr_rst_r  <= scgs_pkg::RST_DEFAULT;
      cdr_mode_r <= scgs_pkg::RST_DEFAULT;
      eq_mode_r  <= scgs_pkg::RST_DEFAULT;
      pll_ctrl_r <= scgs_pkg::RST_DEFAULT;
      pll_div_r  <= scgs_pkg::RST_DEFAULT;
    end else if (reg_wr) begin
      unique case (reg_addr)
        scgs_pkg::ADDR_REF_RATE: ref_rate_r <= reg_wdata;
        scgs_pkg::ADDR_IF_POWER: if_power_r <= reg_wdata;
        scgs_pkg::ADDR_LANE_PD:  lane_pd_r  <= reg_wdata;
        scgs_pkg::ADDR_CDR_RST:  cdr_rst_r  <= reg_wdata;
        scgs_pkg::ADDR_CDR_MODE: cdr_mode_r <= reg_wdata;
        scgs_pkg::ADDR_EQ_MODE:  eq_mode_r  <= reg_wdata;
        scgs_pkg::ADDR_PLL_CTRL: pll_ctrl_r <= reg_wdata;
        scgs_pkg::ADDR_PLL_DIV:  pll_div_r  <= reg_wdata;
        default: ;
      endcase
    end
  end

  // read data registered one cycle after the strobe; unmapped reads zero
  always_ff @(posedge clk) begin
    if (srst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      unique case (reg_addr)
        scgs_pkg::ADDR_REF_RATE: reg_rdata <= ref_rate_r;
        scgs_pkg::ADDR_IF_POWER: reg_rdata <= if_power_r;
        scgs_pkg::ADDR_LANE_PD:  reg_rdata <= lane_pd_r;
        scgs_pkg::ADDR_CDR_RST:  reg_rdata <= cdr_rst_r;
        scgs_pkg::ADDR_CDR_MODE: reg_rdata <= cdr_mode_r;
        scgs_pkg::ADDR_EQ_MODE:  reg_rdata <= eq_mode_r;
        scgs_pkg::ADDR_PLL_CTRL: reg_rdata <= pll_ctrl_r;
        scgs_pkg::ADDR_PLL_STAT: reg_rdata <= pll_stat;
        scgs_pkg::ADDR_PLL_DIV:  reg_rdata <= pll_div_r;
        default:                 reg_rdata <= 8'h00;
      endcase
    end
  end

  // control fields out to the analog side
  always_comb begin
    phy_ctrl.if_pd        = if_power_r[scgs_pkg::IF_PD_BIT];
    phy_ctrl.pll_en       = pll_ctrl_r[scgs_pkg::PLL_EN_BIT];
    phy_ctrl.ref_2x       = ref_rate_r[scgs_pkg::REF_RATE_LSB];
    phy_ctrl.pfd_div      = pll_div_r[1:0];
    phy_ctrl.cdr_half     = cdr_mode_r[scgs_pkg::HALF_RATE_BIT];
    phy_ctrl.cdr_div      = cdr_mode_r[scgs_pkg::CDR_DIV_LSB +: 2];
    phy_ctrl.cdr_rst      = cdr_rst_r[scgs_pkg::CDR_RST_BIT];
    phy_ctrl.eq_low_power = (eq_mode_r[scgs_pkg::EQ_MODE_LSB +: 2]
                             == scgs_pkg::EQ_LOWPWR);
    phy_ctrl.lane_pd      = lane_pd_r;
  end

  // ----------------------------------------------------------------------
  // phase detector divider and pll calibration
  // ----------------------------------------------------------------------
  logic [1:0] pfd_cnt_r, pfd_last;
  logic [7:0] cal_cnt_r;
  logic       cal_busy_r, cal_ok_r, locked_r, band_lo_r, band_hi_r;
  logic       recal_d_r, en_d_r, cal_start;

  // reserved code 11 divides by four, the safe slow choice
  always_comb begin
    unique case (pll_div_r[1:0])
      scgs_pkg::DIV_BY1: pfd_last = 2'd0;
      scgs_pkg::DIV_BY2: pfd_last = 2'd1;
      default:           pfd_last = 2'd3;
    endcase
  end

  // divide the lane-rate/40 reference tick down to the detector rate
  always_ff @(posedge clk) begin
    if (srst) begin
      pfd_cnt_r <= 2'd0;
      pfd_tick  <= 1'b0;
    end else begin
      pfd_tick <= 1'b0;
      if (ref_tick) begin
        if (pfd_cnt_r >= pfd_last) begin
          pfd_cnt_r <= 2'd0;
          pfd_tick  <= 1'b1;
        end else begin
          pfd_cnt_r <= pfd_cnt_r + 2'd1;
        end
      end
    end
  end

  assign cal_start = (pll_ctrl_r[scgs_pkg::PLL_RECAL_BIT] && !recal_d_r)
                     || (phy_ctrl.pll_en && !en_d_r);

  // calibration then lock; band ends are caught as calibration finishes
  always_ff @(posedge clk) begin
    if (srst || !phy_ctrl.pll_en) begin
      cal_cnt_r  <= 8'd0;
      cal_busy_r <= 1'b0;
      cal_ok_r   <= 1'b0;
      locked_r   <= 1'b0;
      band_lo_r  <= 1'b0;
      band_hi_r  <= 1'b0;
    end else if (cal_start) begin
      cal_cnt_r  <= 8'(scgs_pkg::CAL_CYCLES - 1);
      cal_busy_r <= 1'b1;
      cal_ok_r   <= 1'b0;
      locked_r   <= 1'b0;
    end else if (cal_busy_r) begin
      cal_cnt_r <= cal_cnt_r - 8'd1;
      if (cal_cnt_r == 8'd0) begin
        cal_busy_r <= 1'b0;
        band_lo_r  <= vco_band_lo;
        band_hi_r  <= vco_band_hi;
        cal_ok_r   <= !(vco_band_lo || vco_band_hi);
        cal_cnt_r  <= 8'(scgs_pkg::LOCK_CYCLES - 1);
      end
    end else if (cal_ok_r && !locked_r) begin
      cal_cnt_r <= cal_cnt_r - 8'd1;
      locked_r  <= (cal_cnt_r == 8'd0);
    end
  end

  // edge memory for the recalibration and enable bits
  always_ff @(posedge clk) begin
    if (srst) begin
      recal_d_r <= 1'b0;
      en_d_r    <= 1'b0;
    end else begin
      recal_d_r <= pll_ctrl_r[scgs_pkg::PLL_RECAL_BIT];
      en_d_r    <= phy_ctrl.pll_en;
    end
  end

  always_comb begin
    pll_stat = 8'h00;
    pll_stat[scgs_pkg::STAT_LOCK_BIT]    = locked_r;
    pll_stat[scgs_pkg::STAT_CAL_BIT]     = cal_ok_r;
    pll_stat[scgs_pkg::STAT_BAND_LO_BIT] = band_lo_r;
    pll_stat[scgs_pkg::STAT_BAND_HI_BIT] = band_hi_r;
  end

  // ----------------------------------------------------------------------
  // link state: request, alignment, streaming
  // ----------------------------------------------------------------------
  typedef enum logic [1:0] {ST_SYNC, ST_ILAS, ST_DATA} scgs_state_t;
  scgs_state_t state_r;
  logic [LANES-1:0] active, cgs_ok_r, started_r, lane_err;
  logic [LANES-1:0] has_word;
  logic [LANES-1:0][2:0]  run_r;
  logic [LANES-1:0][7:0]  last_oct_r;
  logic [LANES-1:0][AW:0] wptr_r;
  logic [AW:0] rptr_r;
  logic [31:0] mem_r [LANES][DEPTH];
  logic all_cgs, all_started, resync, can_read;

  assign active   = ~lane_pd_r[LANES-1:0];
  assign lane_err = lane_code_err & lane_valid & active;
  assign all_cgs  = (|active) && ((cgs_ok_r & active) == active);
  assign all_started = (started_r & active) == active;
  assign can_read = all_started && ((has_word & active) == active);
  assign resync   = phy_ctrl.if_pd || phy_ctrl.cdr_rst || (|lane_err);
  assign link_sync_request_out = (state_r != ST_SYNC);

  // request held low until every lane not powered down is synced, released on lmfc
  always_ff @(posedge clk) begin
    if (srst) begin
      state_r <= ST_SYNC;
    end else if (resync) begin
      state_r <= ST_SYNC;
    end else begin
      unique case (state_r)
        ST_SYNC: if (all_cgs && lmfc_tick) state_r <= ST_ILAS;
        ST_ILAS: if (all_started) state_r <= ST_DATA;
        ST_DATA: ;
      endcase
    end
  end

  // per-lane code group search and elastic buffer writes
  for (genvar l = 0; l < LANES; l++) begin : g_lane
    logic [2:0] run;
    logic       hit;
    logic [7:0] prev;
    logic [AW:0] level;
    assign level       = wptr_r[l] - rptr_r;
    assign has_word[l] = (level != '0);

    // four octets per cycle: run of K28.5 and /A/ then /R/ search
    always_comb begin
      run  = run_r[l];
      hit  = 1'b0;
      prev = last_oct_r[l];
      for (int i = 0; i < 4; i++) begin
        if (lane_in[l].is_k[i] && lane_in[l].data[8*i +: 8]
            == scgs_pkg::K_SYNC) begin
          run = (run == scgs_pkg::CGS_RUN) ? run : run + 3'd1;
        end else begin
          run = 3'd0;
        end
        if (lane_in[l].is_k[i] && lane_in[l].data[8*i +: 8]
            == scgs_pkg::K_LSTART && prev == scgs_pkg::K_ALIGN) begin
          hit = 1'b1;
        end
        prev = lane_in[l].data[8*i +: 8];
      end
    end

    // code group sync is kept until a code error or a resync
    always_ff @(posedge clk) begin
      if (srst || resync) begin
        run_r[l]      <= 3'd0;
        cgs_ok_r[l]   <= 1'b0;
        last_oct_r[l] <= 8'h00;
      end else if (lane_valid[l]) begin
        run_r[l]      <= run;
        last_oct_r[l] <= lane_in[l].data[31:24];
        if (run == scgs_pkg::CGS_RUN) cgs_ok_r[l] <= 1'b1;
      end
    end

    // early lanes park here until the latest lane has found its start
    always_ff @(posedge clk) begin
      if (srst || state_r == ST_SYNC) begin
        started_r[l] <= 1'b0;
        wptr_r[l]    <= '0;
      end else if (lane_valid[l] && active[l]
                   && (started_r[l] || hit)
                   && level != (AW+1)'(DEPTH)) begin
        started_r[l] <= 1'b1;
        mem_r[l][wptr_r[l][AW-1:0]] <= lane_in[l].data;
        wptr_r[l] <= wptr_r[l] + 1'b1;
      end
    end

    // registered aligned word for this lane
    always_ff @(posedge clk) begin
      if (srst) begin
        aligned_data[l] <= 32'h0000_0000;
      end else if (can_read) begin
        aligned_data[l] <= mem_r[l][rptr_r[AW-1:0]];
      end
    end
  end

  // one shared read pointer releases every lane on the same cycle
  always_ff @(posedge clk) begin
    if (srst || resync || state_r == ST_SYNC) begin
      rptr_r        <= '0;
      aligned_valid <= 1'b0; // no word may follow a resync request
    end else begin
      aligned_valid <= can_read;
      if (can_read) rptr_r <= rptr_r + 1'b1;
    end
  end

  // a full buffer drops words; sticky until the next resync
  always_ff @(posedge clk) begin
    if (srst || state_r == ST_SYNC) begin
      align_overflow <= 1'b0;
    end else begin
      for (int l = 0; l < LANES; l++) begin
        if (lane_valid[l] && started_r[l]
            && (wptr_r[l] - rptr_r) == (AW+1)'(DEPTH)) begin
          align_overflow <= 1'b1;
        end
      end
    end
  end

  // ----------------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------------
  default clocking @(posedge clk); endclocking
  default disable iff (srst);

  AST_PFD_DIV1: assert property (
    ref_tick && $stable(pll_div_r) && pll_div_r[1:0] == scgs_pkg::DIV_BY1
    |=> pfd_tick) else $error("divide by one missed a detector tick");
  AST_RECAL: assert property (
    $rose(pll_ctrl_r[scgs_pkg::PLL_RECAL_BIT]) && phy_ctrl.pll_en
    |=> cal_busy_r ##1 !pll_stat[scgs_pkg::STAT_LOCK_BIT])
    else $error("recalibration did not start");
  AST_LOCK_AFTER_CAL: assert property (
    pll_stat[scgs_pkg::STAT_LOCK_BIT] |-> cal_ok_r && !cal_busy_r)
    else $error("lock shown without calibration");
  AST_BAND_FLAG: assert property (
    $fell(cal_busy_r) && phy_ctrl.pll_en
    |-> band_hi_r == $past(vco_band_hi) && band_lo_r == $past(vco_band_lo))
    else $error("band flag not captured at calibration end");
  AST_LANE_PD: assert property (
    reg_wr && reg_addr == scgs_pkg::ADDR_LANE_PD
    |=> phy_ctrl.lane_pd == $past(reg_wdata))
    else $error("lane power-down not applied");
  AST_EQ_LOW: assert property (
    reg_wr && reg_addr == scgs_pkg::ADDR_EQ_MODE
    && reg_wdata[7:6] == scgs_pkg::EQ_LOWPWR |=> phy_ctrl.eq_low_power)
    else $error("low power equalizer not selected");
  AST_SYNC_RELEASE: assert property (
    $rose(link_sync_request_out) |-> $past(lmfc_tick) && $past(all_cgs))
    else $error("request released off lmfc or before sync");
  AST_LOSS: assert property (
    |lane_err |=> !link_sync_request_out [*2])
    else $error("code error did not reassert request");
  AST_TOGETHER: assert property (
    aligned_valid |-> $past(all_started) && link_sync_request_out)
    else $error("lanes released before all aligned");

  COV_RELEASE: cover property ($rose(link_sync_request_out));
  COV_ALIGNED: cover property (state_r == ST_ILAS ##[1:50] aligned_valid);
  COV_LOCK: cover property ($rose(pll_stat[scgs_pkg::STAT_LOCK_BIT]));

endmodule // scgs_rx_front

// ==== bench/scgs_tx_model.sv ====
// transmitter model: k28.5 fill while sync is requested, then ilas, data
// assumes the receiver clk and a one-cycle lmfc_tick shared with it
`timescale 1ns/1ps
module scgs_tx_model (
  input  wire logic                       clk,
  input  wire logic                       srst,
  input  wire logic                       sync_n,
  input  wire logic                       lmfc_tick,
  input  wire logic                       stall,
  input  wire logic [7:0][1:0]            skew,
  output scgs_pkg::scgs_lane_word_t [7:0] lane_in,
  output logic [7:0]                      lane_valid
);
  // ------------------------------------------------------------------
  // link sequencing
  // ------------------------------------------------------------------
  logic       ilas_r;
  logic [7:0] pos_r [8];

  // ilas waits for an lmfc edge after release; a request restarts fill
  always_ff @(posedge clk) begin
    if (srst || !sync_n) begin
      ilas_r <= 1'b0;
    end else if (lmfc_tick) begin
      ilas_r <= 1'b1;
    end
  end

  // word position per lane, held while stalled
  always_ff @(posedge clk) begin
    for (int i = 0; i < 8; i++) begin
      if (!ilas_r) begin
        pos_r[i] <= 8'h00;
      end else if (!stall) begin
        pos_r[i] <= pos_r[i] + 8'h01;
      end
    end
  end

  // skewed fill, /A/ ends one word, /R/ opens the next, then counts;
  // stalled words are inverted so stale data never looks valid
  always_comb begin
    for (int i = 0; i < 8; i++) begin
      int q;
      q = int'(pos_r[i]) - int'(skew[i]);
      lane_in[i].data = 32'hbcbc_bcbc;
      lane_in[i].is_k = 4'hf;
      if (q == 1) begin
        lane_in[i].data = 32'h7cbc_bcbc;
      end else if (q > 1) begin
        lane_in[i].data = {i[7:0], 8'(q - 2), 8'h5a,
                           q == 2 ? 8'h1c : 8'h96};
        lane_in[i].is_k = q == 2 ? 4'h1 : 4'h0;
      end
      if (stall) begin
        lane_in[i] = ~lane_in[i];
      end
    end
    lane_valid = stall ? 8'h00 : 8'hff;
  end
endmodule // scgs_tx_model

// ==== bench/serdes_rx_phy_and_code_group_sync_bench.sv ====
// self-checking bench for the serial receive front end
// assumes scgs_tx_model on the lanes and a 10 MHz clk
`timescale 1ns/1ps
module serdes_rx_phy_and_code_group_sync_bench;
  localparam logic [11:0] RA [9] = '{scgs_pkg::ADDR_REF_RATE,
    scgs_pkg::ADDR_IF_POWER, scgs_pkg::ADDR_LANE_PD, scgs_pkg::ADDR_CDR_RST,
    scgs_pkg::ADDR_CDR_MODE, scgs_pkg::ADDR_EQ_MODE, scgs_pkg::ADDR_PLL_CTRL,
    scgs_pkg::ADDR_PLL_STAT, scgs_pkg::ADDR_PLL_DIV};
  logic             clk = 1'b0;
  logic             srst = 1'b1;
  logic [11:0]      reg_addr = 12'h000;
  logic             reg_wr = 1'b0;
  logic             reg_rd = 1'b0;
  logic [7:0]       reg_wdata = 8'h00;
  logic [7:0]       reg_rdata;
  logic             ref_tick = 1'b0;
  logic             pfd_tick;
  logic             band_lo = 1'b0;
  logic             band_hi = 1'b0;
  logic             lmfc_tick = 1'b0;
  logic [3:0]       lc = 4'h0;
  logic [7:0]       code_err = 8'h00;
  logic             sync_n;
  logic             aligned_valid;
  logic [7:0][31:0] aligned_data;
  logic             align_overflow;
  logic             stall = 1'b0;
  logic             hold = 1'b0;
  logic [7:0][1:0]  skew = '0;
  logic [7:0]       sh [9];
  logic [7:0]       pd = 8'h00;
  logic [7:0]       v;
  logic             sp = 1'b0;
  logic             tp = 1'b0;
  integer           seed = 32'h0516_b619;
  int               errors = 0;
  int               compares = 0;
  int               cyc = 0;
  int               pfd_n = 0;
  int               nexp = 0;
  scgs_pkg::scgs_phy_ctrl_t        phy_ctrl;
  scgs_pkg::scgs_lane_word_t [7:0] lane_in;
  logic [7:0]       lane_valid;

  always #50 clk = ~clk;

  scgs_rx_front dut (.clk(clk), .srst(srst), .reg_addr(reg_addr),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
    .reg_rdata(reg_rdata), .ref_tick(ref_tick), .pfd_tick(pfd_tick),
    .vco_band_lo(band_lo), .vco_band_hi(band_hi), .phy_ctrl(phy_ctrl),
    .lmfc_tick(lmfc_tick), .lane_in(lane_in), .lane_valid(lane_valid),
    .lane_code_err(code_err), .link_sync_request_out(sync_n),
    .aligned_valid(aligned_valid), .aligned_data(aligned_data),
    .align_overflow(align_overflow));

  scgs_tx_model tx (.clk(clk), .srst(srst), .sync_n(sync_n),
    .lmfc_tick(lmfc_tick), .stall(stall), .skew(skew),
    .lane_in(lane_in), .lane_valid(lane_valid));

  // ------------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp,
                     input string m);
    compares++;
    if (got !== exp) begin
      errors++;
      $display("[FAIL] %0t %s", $time, m);
    end
  endtask

  task automatic close_out();
    $display("errors %0d compares %0d", errors, compares);
    if (errors == 0 && compares > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask

  task automatic wa(input logic [11:0] a, input logic [7:0] d);
    @(negedge clk);
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(negedge clk);
    reg_wr = 1'b0;
  endtask

  task automatic wr(input int i, input logic [7:0] d);
    sh[i] = d;
    wa(RA[i], d);
  endtask

  // read data lands one edge after the strobe
  task automatic rd(input logic [11:0] a, input logic [7:0] e);
    @(negedge clk);
    reg_addr = a;
    reg_rd = 1'b1;
    @(negedge clk);
    reg_rd = 1'b0;
    chk(reg_rdata, e, "read data");
  endtask

  // one error word, with stalls held off so the lane word is taken
  task automatic err(input logic [7:0] m);
    hold = 1'b1;
    @(negedge clk);
    code_err = m;
    @(negedge clk);
    code_err = 8'h00;
    hold = 1'b0;
  endtask

  function automatic scgs_pkg::scgs_phy_ctrl_t dec();
    dec.if_pd = sh[1][0];
    dec.pll_en = sh[6][0];
    dec.ref_2x = sh[0][4];
    dec.pfd_div = sh[8][1:0];
    dec.cdr_half = sh[4][5];
    dec.cdr_div = sh[4][2:1];
    dec.cdr_rst = sh[3][0];
    dec.eq_low_power = sh[5][7:6] == 2'b01;
    dec.lane_pd = sh[2];
  endfunction

  function automatic logic [31:0] ew(input int i, input int n);
    ew = {i[7:0], n[7:0], 8'h5a, n == 0 ? 8'h1c : 8'h96};
  endfunction

  // free-running stimulus: lmfc every 16 cycles, reference every 2
  always @(negedge clk) begin
    lc <= lc + 4'h1;
    lmfc_tick <= lc == 4'hf;
    ref_tick <= ~ref_tick;
    stall <= !hold && ($random(seed) & 3) == 0;
  end

  // release timing, pfd count and the hang limit
  always @(posedge clk) begin
    cyc++;
    sp <= sync_n;
    tp <= lmfc_tick;
    if (pfd_tick === 1'b1) begin
      pfd_n++;
    end
    if (sync_n === 1'b1 && sp === 1'b0) begin
      chk(tp, 1'b1, "release off lmfc");
    end
    if (cyc == 4000) begin
      errors++;
      close_out();
    end
  end

  // aligned words: /R/ word first on all lanes not powered down, then counts in step
  always @(negedge clk) begin
    if (sync_n !== 1'b1) begin
      nexp = 0;
    end else if (aligned_valid === 1'b1) begin
      for (int i = 0; i < 8; i++) begin
        if (!pd[i]) begin
          chk(aligned_data[i], ew(i, nexp), "aligned word");
        end
      end
      nexp++;
    end
  end

  // ------------------------------------------------------------------
  // main sequence
  // ------------------------------------------------------------------
  initial begin
    for (int i = 0; i < 9; i++) begin
      sh[i] = scgs_pkg::RST_DEFAULT;
    end
    sh[1] = scgs_pkg::RST_IF_POWER;
    repeat (10) @(negedge clk);
    srst = 1'b0;
    for (int i = 0; i < 9; i++) begin
      rd(RA[i], sh[i]);
    end
    wa(12'h3ff, 8'h5a);
    rd(12'h3ff, 8'h00);
    wa(RA[7], 8'hff);
    rd(RA[7], 8'h00);
    chk(sync_n, 1'b0, "request after reset");
    for (int k = 0; k < 24; k++) begin
      int i;
      i = k % 8 == 7 ? 8 : k % 8;
      v = 8'($random(seed));
      // interface kept down so no link comes up with random lane masks
      if (i == 1) v[0] = 1'b1;
      wr(i, v);
      rd(RA[i], v);
      chk(phy_ctrl, dec(), "decode");
    end
    for (int e = 0; e < 4; e++) begin
      wr(5, {e[1:0], 6'h3f});
      chk(phy_ctrl.eq_low_power, e == 1, "eq mode");
    end
    // divider codes: pfd rate, then calibration and lock
    for (int d = 0; d < 4; d++) begin
      int dv;
      dv = d == 1 ? 2 : d == 2 ? 1 : 4;
      wr(6, 8'h00);
      wr(0, d == 2 ? 8'h10 : 8'h00);
      wr(8, d[7:0]);
      wr(6, 8'h01);
      pfd_n = 0;
      repeat (80) @(negedge clk);
      chk(pfd_n * dv >= 40 - dv && pfd_n * dv <= 40 + dv, 1, "pfd");
      rd(RA[7], 8'h09);
    end
    // band ends flag and block lock; a clean recal clears them
    for (int b = 1; b < 4; b++) begin
      band_lo = b == 1;
      band_hi = b == 2;
      wr(6, 8'h05);
      wr(6, 8'h01);
      repeat (80) @(negedge clk);
      rd(RA[7], b == 1 ? 8'h10 : b == 2 ? 8'h20 : 8'h09);
    end
    wr(6, 8'h00);
    wr(6, 8'h04);
    repeat (80) @(negedge clk);
    rd(RA[7], 8'h00);
    // link rounds; the first two end by a code error on different lanes, the last by cdr reset
    for (int r = 0; r < 3; r++) begin
      int w;
      pd = r == 1 ? 8'h80 : 8'h00;
      for (int i = 0; i < 8; i++) begin
        skew[i] = 2'($random(seed));
      end
      wr(3, 8'h00);
      wr(8, 8'h00);
      wr(4, 8'h20);
      wr(2, pd);
      wr(1, 8'h00);
      chk(phy_ctrl, dec(), "decode");
      w = 0;
      while (nexp < 40 && w < 400) begin
        @(negedge clk);
        w++;
      end
      chk(nexp >= 40, 1, "aligned stream");
      chk(align_overflow, 1'b0, "overflow");
      if (r == 1) begin
        err(8'h80);
        repeat (3) @(negedge clk);
        chk(sync_n, 1'b1, "error on idle lane");
      end
      if (r == 2) begin
        wr(3, 8'h01);
      end else begin
        err(r == 0 ? 8'h01 : 8'h08);
      end
      w = 0;
      while (sync_n !== 1'b0 && w < 3) begin
        @(negedge clk);
        w++;
      end
      chk(sync_n, 1'b0, "resync request");
      wr(3, 8'h00);
    end
    close_out();
  end
endmodule // serdes_rx_phy_and_code_group_sync_bench
